// [rtl/serial_mem_consts.svh]
`ifndef SERIAL_MEM_CONSTS_SVH
`define SERIAL_MEM_CONSTS_SVH

// Array geometry.
`define MEM_DEPTH      8192
`define MEM_ADDR_W     13
`define ADDR_HI_W      5

// Slave address layout.
`define SLV_TYPE_MSB   7
`define SLV_TYPE_LSB   4
`define SLV_SEL_MSB    3
`define SLV_SEL_LSB    1
`define SLV_RW_BIT     0
// Device-type code; the value is arbitrary.
`define DEV_TYPE_CODE  4'h6

// Bit counts.
`define BITS_PER_BYTE  4'h8

// Link clock divider: one quarter of a serial clock period.
`define SYS_CLK_NS     8
`define SCL_QTR_NS     40
`define SCL_QTR_CYC    ((`SCL_QTR_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

// [rtl/serial_mem_pkg.sv]
package serial_mem_pkg;

  // Device end: one state per byte role, plus the acknowledge slots.
  typedef enum logic [2:0] {
    DS_IDLE, DS_SLV, DS_AHI, DS_ALO, DS_WDAT, DS_ACK, DS_RDAT, DS_RACK
  } dev_state_t;

  // Master end bus sequencer.
  typedef enum logic [1:0] {
    MS_IDLE, MS_START, MS_BIT, MS_STOP
  } mst_state_t;

  // Which byte the master is moving.
  typedef enum logic [1:0] {
    PH_SLV, PH_AHI, PH_ALO, PH_DATA
  } mst_phase_t;

endpackage

// [rtl/serial_link_if.sv]
`timescale 1ns/1ps
interface serial_link_if;
  // Resolved wire levels, pulled up when nobody drives low.
  logic scl_line;
  logic sda_line;
  // Master drives.
  logic m_scl_out;
  logic m_scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  // Device drives.
  logic d_sda_out;
  logic d_sda_oe;

  // Open-drain wired-AND of every enabled driver.
  assign scl_line = ~(m_scl_oe & ~m_scl_out);
  assign sda_line = ~((m_sda_oe & ~m_sda_out) | (d_sda_oe & ~d_sda_out));

  modport device (input scl_line, input sda_line, output d_sda_out, output d_sda_oe);
  modport master (input scl_line, input sda_line,
                  output m_scl_out, output m_scl_oe, output m_sda_out, output m_sda_oe);
endinterface

// [rtl/byte_mem_slave.sv]
`timescale 1ns/1ps
`include "serial_mem_consts.svh"
module byte_mem_slave (
  // System.
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  // Two-wire link.
  serial_link_if.device                 link,
  // Straps.
  input  wire logic [2:0]               device_select_pins,
  input  wire logic                     write_protect_pin,
  // Status.
  output logic [`MEM_ADDR_W-1:0]        cur_addr
);
  import serial_mem_pkg::*;

  // Next address with natural wrap from the last location to zero.
  function automatic logic [`MEM_ADDR_W-1:0] addr_inc(input logic [`MEM_ADDR_W-1:0] a);
    addr_inc = a + `MEM_ADDR_W'(1);
  endfunction

  logic [7:0]             mem [0:`MEM_DEPTH-1];
  logic                   scl_s1;
  logic                   scl_s2;
  logic                   scl_p;
  logic                   sda_s1;
  logic                   sda_s2;
  logic                   sda_p;
  logic                   wp_s1;
  logic                   wp_s2;
  logic [2:0]             sel_s1;
  logic [2:0]             sel_s2;
  dev_state_t             state;
  dev_state_t             next_state;
  dev_state_t             after;
  dev_state_t             next_after;
  logic [3:0]             cnt;
  logic [3:0]             next_cnt;
  logic [7:0]             shreg;
  logic [7:0]             next_shreg;
  logic [`MEM_ADDR_W-1:0] addr;
  logic [`MEM_ADDR_W-1:0] next_addr;
  logic [`ADDR_HI_W-1:0]  addr_hi;
  logic [`ADDR_HI_W-1:0]  next_addr_hi;
  logic                   sda_oe;
  logic                   next_sda_oe;
  logic                   mem_we;
  logic [`MEM_ADDR_W-1:0] mem_wa;
  logic [7:0]             mem_wd;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_c;
  logic                   stop_c;
  logic [7:0]             rx_byte;
  logic [7:0]             rd_byte;

  // Every pin crosses two flops; only the second stage and its delayed copy feed logic.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_p  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_p  <= 1'b1;
      wp_s1  <= 1'b0;
      wp_s2  <= 1'b0;
      sel_s1 <= 3'h0;
      sel_s2 <= 3'h0;
    end else begin
      scl_s1 <= link.scl_line;
      scl_s2 <= scl_s1;
      scl_p  <= scl_s2;
      sda_s1 <= link.sda_line;
      sda_s2 <= sda_s1;
      sda_p  <= sda_s2;
      wp_s1  <= write_protect_pin;
      wp_s2  <= wp_s1;
      sel_s1 <= device_select_pins;
      sel_s2 <= sel_s1;
    end
  end

  // Edge and condition detection in the system clock domain.
  assign scl_rise = scl_s2 & ~scl_p;
  assign scl_fall = ~scl_s2 & scl_p;
  assign start_c  = scl_s2 & scl_p & sda_p & ~sda_s2;
  assign stop_c   = scl_s2 & scl_p & ~sda_p & sda_s2;
  assign rx_byte  = {shreg[6:0], sda_s2};
  assign rd_byte  = mem[addr];

  // Protocol sequencer: one byte role per state, bit count in cnt.
  always_comb begin
    next_state   = state;
    next_after   = after;
    next_cnt     = cnt;
    next_shreg   = shreg;
    next_addr    = addr;
    next_addr_hi = addr_hi;
    next_sda_oe  = sda_oe;
    mem_we       = 1'b0;
    mem_wa       = addr;
    mem_wd       = rx_byte;
    if (start_c) begin
      next_state  = DS_SLV;
      next_cnt    = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop_c) begin
      next_state  = DS_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        DS_SLV, DS_AHI, DS_ALO, DS_WDAT: begin
          if (scl_rise && cnt < `BITS_PER_BYTE) begin
            next_shreg = rx_byte;
            next_cnt   = cnt + 4'h1;
            if (cnt == `BITS_PER_BYTE - 4'h1) begin
              case (state)
                DS_SLV: begin
                  if (rx_byte[`SLV_TYPE_MSB:`SLV_TYPE_LSB] == `DEV_TYPE_CODE &&
                      rx_byte[`SLV_SEL_MSB:`SLV_SEL_LSB] == sel_s2) begin
                    next_after = rx_byte[`SLV_RW_BIT] ? DS_RDAT : DS_AHI;
                  end else begin
                    next_after = DS_IDLE;
                  end
                end
                DS_AHI: begin
                  next_addr_hi = rx_byte[`ADDR_HI_W-1:0];
                  next_after   = DS_ALO;
                end
                DS_ALO: begin
                  next_addr  = {addr_hi, rx_byte};
                  next_after = DS_WDAT;
                end
                default: begin
                  if (!wp_s2) begin
                    mem_we     = 1'b1;
                    next_addr  = addr_inc(addr);
                    next_after = DS_WDAT;
                  end else begin
                    next_after = DS_IDLE;
                  end
                end
              endcase
            end
          end else if (scl_fall && cnt == `BITS_PER_BYTE) begin
            // A refused byte leaves the line released and drops back to idle.
            if (after == DS_IDLE) begin
              next_state = DS_IDLE;
            end else begin
              next_state  = DS_ACK;
              next_sda_oe = 1'b1;
            end
          end
        end
        DS_ACK: begin
          // Release at the end of the ninth clock; a read drives its first bit now.
          if (scl_fall) begin
            next_state  = after;
            next_cnt    = 4'h0;
            next_sda_oe = 1'b0;
            if (after == DS_RDAT) begin
              next_shreg  = rd_byte;
              next_sda_oe = ~rd_byte[7];
            end
          end
        end
        DS_RDAT: begin
          if (scl_rise) begin
            next_cnt = cnt + 4'h1;
            if (cnt == `BITS_PER_BYTE - 4'h1) begin
              next_addr = addr_inc(addr);
            end
          end else if (scl_fall) begin
            if (cnt == `BITS_PER_BYTE) begin
              next_state  = DS_RACK;
              next_cnt    = 4'h0;
              next_sda_oe = 1'b0;
            end else begin
              next_shreg  = {shreg[6:0], 1'b0};
              next_sda_oe = ~shreg[6];
            end
          end
        end
        DS_RACK: begin
          if (scl_rise) begin
            if (sda_s2) begin
              next_state = DS_IDLE;
            end else begin
              next_cnt = 4'h1;
            end
          end else if (scl_fall && cnt == 4'h1) begin
            next_state  = DS_RDAT;
            next_cnt    = 4'h0;
            next_shreg  = rd_byte;
            next_sda_oe = ~rd_byte[7];
          end
        end
        default: begin
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Sequencer registers; the latch is cleared only by the system reset.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state   <= DS_IDLE;
      after   <= DS_IDLE;
      cnt     <= 4'h0;
      shreg   <= 8'h00;
      addr    <= '0;
      addr_hi <= '0;
      sda_oe  <= 1'b0;
    end else begin
      state   <= next_state;
      after   <= next_after;
      cnt     <= next_cnt;
      shreg   <= next_shreg;
      addr    <= next_addr;
      addr_hi <= next_addr_hi;
      sda_oe  <= next_sda_oe;
    end
  end

  // The array is written straight from the shifter, so no busy time follows.
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Open-drain drive only: the pad pulls low when enabled, the pull-up gives the high level.
  assign link.d_sda_out = 1'b0;
  assign link.d_sda_oe  = sda_oe;
  assign cur_addr       = addr;
endmodule

// [rtl/byte_mem_master.sv]
`timescale 1ns/1ps
`include "serial_mem_consts.svh"
module byte_mem_master (
  // System.
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  // Two-wire link.
  serial_link_if.master                 link,
  // Command.
  input  wire logic                     cmd_req,
  input  wire logic                     cmd_write,
  input  wire logic [2:0]               cmd_sel,
  input  wire logic [`MEM_ADDR_W-1:0]   cmd_addr,
  input  wire logic [7:0]               cmd_len,
  output logic                          cmd_busy,
  output logic                          cmd_done,
  output logic                          cmd_nack,
  // Write data.
  input  wire logic [7:0]               wr_data,
  output logic                          wr_take,
  // Read data.
  output logic [7:0]                    rd_data,
  output logic                          rd_valid
);
  import serial_mem_pkg::*;

  localparam int QTR = `SCL_QTR_CYC;

  logic       sda_s1;
  logic       sda_s2;
  mst_state_t state;
  mst_state_t next_state;
  mst_phase_t phase;
  mst_phase_t next_phase;
  logic [7:0] tick;
  logic [7:0] next_tick;
  logic [1:0] qtr;
  logic [1:0] next_qtr;
  logic [3:0] bitn;
  logic [3:0] next_bitn;
  logic [7:0] txb;
  logic [7:0] next_txb;
  logic [7:0] rxb;
  logic [7:0] next_rxb;
  logic [7:0] left;
  logic [7:0] next_left;
  logic       wr;
  logic       next_wr;
  logic [`MEM_ADDR_W-1:0] maddr;
  logic [`MEM_ADDR_W-1:0] next_maddr;
  logic       scl_oe;
  logic       next_scl_oe;
  logic       sda_oe;
  logic       next_sda_oe;
  logic       nack;
  logic       next_nack;
  logic       next_done;
  logic       next_take;
  logic       next_rvalid;
  logic [7:0] next_rdata;
  logic       step;
  logic       rx_phase;

  // Data line crosses two flops before it is sampled.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= link.sda_line;
      sda_s2 <= sda_s1;
    end
  end

  // Quarter-period tick, and whether the byte on the wire comes from the slave.
  assign step     = (tick == 8'(QTR - 1));
  assign rx_phase = (phase == PH_DATA) && !wr;

  // Quarter-period sequencer; during a bit, data changes only in quarter 0 while the clock is low.
  always_comb begin
    next_state  = state;
    next_phase  = phase;
    next_tick   = step ? 8'h00 : tick + 8'h01;
    next_qtr    = qtr;
    next_bitn   = bitn;
    next_txb    = txb;
    next_rxb    = rxb;
    next_left   = left;
    next_wr     = wr;
    next_maddr  = maddr;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_nack   = nack;
    next_done   = 1'b0;
    next_take   = 1'b0;
    next_rvalid = 1'b0;
    next_rdata  = rd_data;
    case (state)
      MS_IDLE: begin
        next_tick = 8'h00;
        if (cmd_req) begin
          next_state = MS_START;
          next_qtr   = 2'h0;
          next_wr    = cmd_write;
          next_maddr = cmd_addr;
          next_left  = (cmd_len == 8'h00 && !cmd_write) ? 8'h01 : cmd_len;
          next_txb   = {`DEV_TYPE_CODE, cmd_sel, ~cmd_write};
          next_phase = PH_SLV;
          next_nack  = 1'b0;
        end
      end
      MS_START: begin
        if (step) begin
          next_qtr = qtr + 2'h1;
          if (qtr == 2'h0) begin
            next_sda_oe = 1'b1;
          end else if (qtr == 2'h1) begin
            next_scl_oe = 1'b1;
            next_state  = MS_BIT;
            next_qtr    = 2'h0;
            next_bitn   = 4'h0;
          end
        end
      end
      MS_BIT: begin
        if (step) begin
          next_qtr = qtr + 2'h1;
          case (qtr)
            2'h0: begin
              if (bitn < `BITS_PER_BYTE) begin
                next_sda_oe = rx_phase ? 1'b0 : ~txb[7];
              end else begin
                // Acknowledge every read byte but the last.
                next_sda_oe = rx_phase && (left != 8'h01);
              end
            end
            2'h1: next_scl_oe = 1'b0;
            2'h2: begin
              if (bitn < `BITS_PER_BYTE) begin
                next_rxb = {rxb[6:0], sda_s2};
              end else if (!rx_phase) begin
                next_nack = sda_s2;
              end
            end
            default: begin
              next_scl_oe = 1'b1;
              next_bitn   = bitn + 4'h1;
              if (bitn < `BITS_PER_BYTE) begin
                next_txb = {txb[6:0], 1'b0};
              end else begin
                next_bitn = 4'h0;
                if (!rx_phase && nack) begin
                  next_state = MS_STOP;
                end else begin
                  case (phase)
                    PH_SLV: begin
                      next_phase = wr ? PH_AHI : PH_DATA;
                      next_txb   = 8'(maddr >> 8);
                    end
                    PH_AHI: begin
                      next_phase = PH_ALO;
                      next_txb   = maddr[7:0];
                    end
                    default: begin
                      if (phase == PH_DATA) begin
                        next_left = left - 8'h01;
                        if (!wr) begin
                          next_rvalid = 1'b1;
                          next_rdata  = rxb;
                        end
                      end
                      next_phase = PH_DATA;
                      if ((phase == PH_DATA ? left - 8'h01 : left) == 8'h00) begin
                        next_state = MS_STOP;
                      end else if (wr) begin
                        next_txb  = wr_data;
                        next_take = 1'b1;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
      end
      default: begin
        // Stop: data low, clock up, then data up while the clock is high.
        if (step) begin
          next_qtr = qtr + 2'h1;
          case (qtr)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b0;
            default: begin
              next_state = MS_IDLE;
              next_done  = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state    <= MS_IDLE;
      phase    <= PH_SLV;
      tick     <= 8'h00;
      qtr      <= 2'h0;
      bitn     <= 4'h0;
      txb      <= 8'h00;
      rxb      <= 8'h00;
      left     <= 8'h00;
      wr       <= 1'b0;
      maddr    <= '0;
      scl_oe   <= 1'b0;
      sda_oe   <= 1'b0;
      nack     <= 1'b0;
      cmd_done <= 1'b0;
      wr_take  <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
    end else begin
      state    <= next_state;
      phase    <= next_phase;
      tick     <= next_tick;
      qtr      <= next_qtr;
      bitn     <= next_bitn;
      txb      <= next_txb;
      rxb      <= next_rxb;
      left     <= next_left;
      wr       <= next_wr;
      maddr    <= next_maddr;
      scl_oe   <= next_scl_oe;
      sda_oe   <= next_sda_oe;
      nack     <= next_nack;
      cmd_done <= next_done;
      wr_take  <= next_take;
      rd_valid <= next_rvalid;
      rd_data  <= next_rdata;
    end
  end

  // Both lines are open drain; the pull-ups give the high level.
  assign link.m_scl_out = 1'b0;
  assign link.m_scl_oe  = scl_oe;
  assign link.m_sda_out = 1'b0;
  assign link.m_sda_oe  = sda_oe;
  assign cmd_busy       = (state != MS_IDLE);
  assign cmd_nack       = nack;
endmodule

// [verification/byte_mem_monitor.sv]
`timescale 1ns/1ps
`include "serial_mem_consts.svh"
module byte_mem_monitor (
  // System.
  input wire logic sys_clk,
  input wire logic srst,
  // Link wires and enables.
  input wire logic scl_line,
  input wire logic sda_line,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic d_sda_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  logic       scl_q;
  logic       sda_q;
  logic       first;
  logic       rd;
  logic [3:0] cnt;
  logic [7:0] shreg;
  wire        rise  = scl_line & ~scl_q;
  wire        start = scl_line & scl_q & sda_q & ~sda_line;
  wire        stop  = scl_line & scl_q & ~sda_q & sda_line;
  wire        rmode = rd & ~first;

  // Tracks bit position and direction since the last START, so ack slots can be located.
  always_ff @(posedge sys_clk) begin
    scl_q <= scl_line;
    sda_q <= sda_line;
    if (srst || start) begin
      cnt   <= 4'h0;
      first <= 1'b1;
      rd    <= 1'b0;
    end else if (rise) begin
      shreg <= {shreg[6:0], sda_line};
      cnt   <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h8) first <= 1'b0;
      if (first && cnt == 4'h7) rd <= sda_line;
    end
  end

  // The device must stay off the data line for a while after a condition.
  sequence s_quiet;
    !d_sda_oe [*8];
  endsequence
  sequence s_nack_rise;
    rise && rmode && cnt == 4'h8 && sda_line;
  endsequence

  reset_release_a: assert property ($fell(srst)
    |-> !d_sda_oe && !m_sda_oe && !m_scl_oe) else $error("link not released after reset");
  sda_hold_a: assert property (scl_line && $past(scl_line) && $changed(sda_line)
    |-> $changed(m_sda_oe) && !d_sda_oe) else $error("data changed while clock high");
  start_quiet_a: assert property (start |-> s_quiet)
    else $error("device drove data after start");
  stop_quiet_a: assert property (stop |-> s_quiet)
    else $error("device drove data after stop");
  ack_slot_a: assert property ($rose(d_sda_oe) && !rmode |-> cnt == 4'h8)
    else $error("device ack outside ninth clock");
  ack_hold_a: assert property ($rose(d_sda_oe) && !rmode |-> d_sda_oe [*8])
    else $error("device ack not held");
  type_match_a: assert property (rise && first && cnt == 4'h8 && !sda_line
    |-> shreg[7:4] == `DEV_TYPE_CODE) else $error("ack for foreign type code");
  read_nack_a: assert property (s_nack_rise |-> ##11 s_quiet)
    else $error("device kept sending after nack");
endmodule

// [verification/i2c_slave_byte_memory_bench.sv]
`timescale 1ns/1ps
`include "serial_mem_consts.svh"
module i2c_slave_byte_memory_bench;
  localparam logic [2:0] PINS = 3'h5;
  logic                   sys_clk;
  logic                   srst;
  logic                   cmd_req;
  logic                   cmd_write;
  logic                   write_protect_pin;
  logic                   cmd_busy;
  logic                   cmd_done;
  logic                   cmd_nack;
  logic                   wr_take;
  logic                   rd_valid;
  logic [2:0]             cmd_sel;
  logic [2:0]             device_select_pins;
  logic [`MEM_ADDR_W-1:0] cmd_addr;
  logic [`MEM_ADDR_W-1:0] cur_addr;
  logic [7:0]             cmd_len;
  logic [7:0]             wr_data;
  logic [7:0]             rd_data;
  logic [7:0]             wbuf [0:3];
  logic [7:0]             rq [$];
  int                     widx;
  int                     error_cnt;
  int                     n_tests;

  serial_link_if link_if ();
  byte_mem_slave byte_mem_slave_inst (.sys_clk(sys_clk), .srst(srst), .link(link_if),
    .device_select_pins(device_select_pins), .write_protect_pin(write_protect_pin),
    .cur_addr(cur_addr));
  byte_mem_master byte_mem_master_inst (.sys_clk(sys_clk), .srst(srst), .link(link_if),
    .cmd_req(cmd_req), .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_nack(cmd_nack),
    .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid));
  byte_mem_monitor byte_mem_monitor_inst (.sys_clk(sys_clk), .srst(srst),
    .scl_line(link_if.scl_line), .sda_line(link_if.sda_line), .m_scl_oe(link_if.m_scl_oe),
    .m_sda_oe(link_if.m_sda_oe), .d_sda_oe(link_if.d_sda_oe));

  // Free-running system clock.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Next write byte follows each take; read bytes are queued when they arrive.
  always @(negedge sys_clk) begin
    if (wr_take === 1'b1) begin
      widx = widx + 1;
      wr_data <= wbuf[widx % 4];
    end
    if (rd_valid === 1'b1) rq.push_back(rd_data);
  end

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s, got %h, expected %h", $time, what, got, exp);
    end
  endtask

  // One whole command; a hang counts as a mismatch rather than stalling the run.
  task automatic cmd(input logic wr, input logic [2:0] sel, input logic [12:0] addr,
                     input logic [7:0] len);
    int t;
    @(negedge sys_clk);
    cmd_write = wr;
    cmd_sel = sel;
    cmd_addr = addr;
    cmd_len = len;
    widx = 0;
    wr_data = wbuf[0];
    rq = {};
    cmd_req = 1'b1;
    @(negedge sys_clk);
    cmd_req = 1'b0;
    check(16'(cmd_busy), 16'h0001, "not busy after request");
    t = 0;
    while (cmd_done !== 1'b1 && t < 4000) begin
      @(negedge sys_clk);
      t++;
    end
    check(16'(t < 4000), 16'h0001, "command timed out");
    check(16'(cmd_busy), 16'h0000, "still busy after done");
  endtask

  // Burst write, set the latch back, then a read that starts from the latch.
  task automatic t_seq;
    wbuf = '{8'hA5, 8'h3C, 8'h81, 8'h00};
    cmd(1'b1, PINS, 13'h0010, 8'h03);
    check(16'(cmd_nack), 16'h0000, "burst write refused");
    check(16'(cur_addr), 16'h0013, "latch after burst");
    cmd(1'b1, PINS, 13'h0010, 8'h00);
    check(16'(cur_addr), 16'h0010, "latch not loaded");
    cmd(1'b0, PINS, 13'h0000, 8'h03);
    check(16'(rq.size()), 16'h0003, "read byte count");
    for (int i = 0; i < 3; i++) check(16'(rq[i]), 16'(wbuf[i]), "read data");
    check(16'(cur_addr), 16'h0013, "latch after read");
  endtask

  // Latch rolls over the top of the array; commands follow a write at once.
  task automatic t_wrap;
    wbuf = '{8'h5A, 8'hC3, 8'h00, 8'h00};
    cmd(1'b1, PINS, 13'h1FFF, 8'h02);
    check(16'(cur_addr), 16'h0001, "latch did not wrap");
    cmd(1'b1, PINS, 13'h1FFF, 8'h00);
    check(16'(cmd_nack), 16'h0000, "refused right after write");
    cmd(1'b0, PINS, 13'h0000, 8'h02);
    check(16'(rq[0]), 16'h005A, "top byte");
    check(16'(rq[1]), 16'h00C3, "wrapped byte");
  endtask

  // Every select value: only the strapped one is answered and moves the latch.
  task automatic t_select;
    logic [12:0] ea;
    ea = 13'h0001;
    for (int s = 0; s < 8; s++) begin
      cmd(1'b1, 3'(s), 13'h0100, 8'h00);
      if (3'(s) == PINS) ea = 13'h0100;
      check(16'(cmd_nack), 16'(3'(s) != PINS), "select answer");
      check(16'(cur_addr), 16'(ea), "latch after select");
    end
  endtask

  // Protected data byte is refused, not stored and leaves the latch alone.
  task automatic t_protect;
    wbuf = '{8'h77, 8'h00, 8'h00, 8'h00};
    cmd(1'b1, PINS, 13'h0040, 8'h01);
    check(16'(cmd_nack), 16'h0000, "open write refused");
    write_protect_pin = 1'b1;
    repeat (4) @(negedge sys_clk);
    wbuf[0] = 8'h11;
    cmd(1'b1, PINS, 13'h0040, 8'h01);
    check(16'(cmd_nack), 16'h0001, "protected byte acknowledged");
    check(16'(cur_addr), 16'h0040, "protected latch moved");
    write_protect_pin = 1'b0;
    cmd(1'b0, PINS, 13'h0000, 8'h01);
    check(16'(rq[0]), 16'h0077, "protected byte stored");
    check(16'(cur_addr), 16'h0041, "latch after single read");
  endtask

  // Watchdog: the scenarios need about 9,000 cycles, so 40,000 leaves ample margin.
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    print_verdict;
  end

  // Main sequence.
  initial begin
    srst = 1'b1;
    cmd_req = 1'b0;
    cmd_write = 1'b0;
    cmd_sel = 3'h0;
    cmd_addr = 13'h0000;
    cmd_len = 8'h00;
    wr_data = 8'h00;
    write_protect_pin = 1'b0;
    device_select_pins = PINS;
    error_cnt = 0;
    n_tests = 0;
    widx = 0;
    repeat (5) @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(16'(cur_addr), 16'h0000, "latch after reset");
    t_seq;
    t_wrap;
    t_select;
    t_protect;
    print_verdict;
  end
endmodule
